// File: src/odc_pkg.sv
// Constants for the octal converter serial control core
package odc_pkg;
    localparam int unsigned WORD_BITS     = 16;
    localparam int unsigned DATA_BITS     = 12;
    localparam int unsigned ADDR_MSB      = 15;
    localparam int unsigned ADDR_LSB      = 12;
    localparam int unsigned CHANNELS      = 8;
    localparam int unsigned PAIRS         = 4;
    localparam int unsigned CNT_BITS      = 5;
    localparam logic [4:0]  CNT_FULL      = 5'h10;
    localparam logic [3:0]  ADDR_MAIN     = 4'h8;
    localparam logic [3:0]  ADDR_PAIR     = 4'h9;
    localparam logic [3:0]  ADDR_PRESET   = 4'ha;
    localparam logic [3:0]  ADDR_RSVD     = 4'hb;
    localparam int unsigned MAIN_PD_BIT   = 4;
    localparam int unsigned MAIN_DO_BIT   = 3;
    localparam int unsigned MAIN_REF_HI   = 2;
    localparam int unsigned MAIN_REF_LO   = 1;
    localparam int unsigned MAIN_FMT_BIT  = 0;
    localparam int unsigned PAIR_PD_LSB   = 4;
    localparam int unsigned PAIR_SPD_LSB  = 0;
    localparam logic [7:0]  CTRL_MASK     = 8'hff;
    localparam logic [4:0]  MAIN_MASK     = 5'h1f;
    localparam logic [11:0] MASK_FULL     = 12'hfff;
    localparam logic [11:0] MASK_TEN      = 12'hffc;
    localparam logic [11:0] MASK_EIGHT    = 12'hff0;
    localparam logic [11:0] CODE_RESET    = 12'h000;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [1:0]  RES_12        = 2'h0;
    localparam logic [1:0]  RES_10        = 2'h1;
    localparam logic [1:0]  RES_8         = 2'h2;
endpackage

// File: src/odc_sync.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module odc_sync
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Level in and out
    input  wire logic d_async,
    output var  logic q_sync
);
    logic meta;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta   <= 1'b0;
            q_sync <= 1'b0;
        end
        else
        begin
            meta   <= d_async;
            q_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// File: src/odc_core.sv
// Serial control core of an eight channel converter
// Overview of operation
// - Word is four address, twelve payload bits
// - Addresses zero to seven load one channel
// - Pair addresses load channel and complement
// - Variant ignores low payload bits
// - Preset low plus load drives preset everywhere
// - Preset register resets to zero
// - Preset input synchronised before use
// - Main bit four powers device down
// - Main bit three enables sixteen-cycle pass-through
// - Main bits two-one select reference
// - Main bit zero selects code format
// - Pair bits seven-four power pairs down
// - Pair bits three-zero select pair speed
// - Strobe fall starts word, MSB first
// - Sixteen bits move word to holding
// - Load low copies holding to outputs
// - Early strobe rise cancels in host mode
`timescale 1ns/10ps
`default_nettype none
module odc_core
#(
    parameter logic [1:0] RESOLUTION = odc_pkg::RES_12
)
(
    // Core clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Serial link, sampled on falling link clock
    input  wire logic        link_clk,
    input  wire logic        frame_strobe_b,
    input  wire logic        serial_in,
    input  wire logic        host_mode,
    output var  logic        serial_out,
    output var  logic        serial_out_en,
    // Update pins
    input  wire logic        load_input_b,
    input  wire logic        preset_b,
    // Converter controls
    output var  logic [95:0] channel_codes,
    output var  logic        device_powerdown,
    output var  logic [1:0]  reference_select,
    output var  logic        code_format,
    output var  logic [3:0]  pair_powerdown,
    output var  logic [3:0]  pair_speed
);
    // Shifter state, on falling link clock
    typedef struct packed {
        logic [15:0] shreg;
        logic [4:0]  cnt;
        logic        fs_q;
    } odc_shift_s;

    // Link domain state, on falling link clock
    typedef struct packed {
        logic [15:0] word;
        logic        tgl;
        logic [15:0] delay;
    } odc_link_s;

    odc_shift_s  shf;
    odc_shift_s  next_shf;
    odc_link_s   lnk;
    odc_link_s   next_lnk;
    logic        shift_done;
    logic        frame_arst_b;
    logic        do_en_link_m;
    logic        do_en_link;
    logic [4:0]  main_reg;

    // Link clock may stand still once the strobe rises, so host framing
    // clears the shifter without a clock edge; the strobe must be glitch free
    assign frame_arst_b = rst_b & ~(host_mode & frame_strobe_b);

    // Pass-through enable crosses into link domain; rare change, so level sync
    always_ff @(negedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            do_en_link_m <= 1'b0;
            do_en_link   <= 1'b0;
        end
        else
        begin
            do_en_link_m <= main_reg[odc_pkg::MAIN_DO_BIT];
            do_en_link   <= do_en_link_m;
        end
    end

    always_comb
    begin
        next_shf      = shf;
        shift_done    = 1'b0;
        next_shf.fs_q = frame_strobe_b;
        if (!frame_strobe_b && (shf.fs_q || shf.cnt == 5'h00))
        begin
            next_shf.shreg = {15'h0000, serial_in};
            next_shf.cnt   = 5'h01;
        end
        else if (shf.cnt != 5'h00 && shf.cnt < odc_pkg::CNT_FULL
                 && (!frame_strobe_b || !host_mode))
        begin
            // Processor framing may lift the strobe early; keep counting
            next_shf.shreg = {shf.shreg[14:0], serial_in};
            next_shf.cnt   = shf.cnt + 5'h01;
            shift_done     = (next_shf.cnt == odc_pkg::CNT_FULL);
        end
    end

    always_ff @(negedge link_clk or negedge frame_arst_b)
    begin
        if (!frame_arst_b)
            shf <= '0;
        else
            shf <= next_shf;
    end

    always_comb
    begin
        next_lnk       = lnk;
        next_lnk.delay = {lnk.delay[14:0], serial_in};
        if (shift_done)
        begin
            next_lnk.word = next_shf.shreg;
            next_lnk.tgl  = ~lnk.tgl;
        end
    end

    always_ff @(negedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
            lnk <= '0;
        else
            lnk <= next_lnk;
    end

    // Core domain state
    typedef struct packed {
        logic [2:0]  tgl_s;
        logic        pend;
        logic [95:0] hold;
        logic [95:0] latch;
        logic [11:0] preset;
        logic [4:0]  main;
        logic [7:0]  pair;
    } odc_core_s;

    odc_core_s   cs;
    odc_core_s   next_cs;
    logic        load_s;
    logic        preset_s;
    logic        strobe_s;
    logic        take;
    logic [3:0]  wa;
    logic [11:0] raw;
    logic [11:0] pay;

    assign main_reg = cs.main;

    function automatic logic [11:0] trim(input logic [11:0] v);
        case (RESOLUTION)
            odc_pkg::RES_10: trim = v & odc_pkg::MASK_TEN;
            odc_pkg::RES_8:  trim = v & odc_pkg::MASK_EIGHT;
            default:         trim = v & odc_pkg::MASK_FULL;
        endcase
    endfunction

    odc_sync u_load_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .d_async  (load_input_b),
        .q_sync   (load_s)
    );

    odc_sync u_preset_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .d_async  (preset_b),
        .q_sync   (preset_s)
    );

    // Strobe level seen in core domain, for the host-framing update
    odc_sync u_strobe_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .d_async  (frame_strobe_b),
        .q_sync   (strobe_s)
    );

    always_comb
    begin
        next_cs = cs;
        // Word is stable well before its toggle lands through the sync
        next_cs.tgl_s = {cs.tgl_s[1:0], lnk.tgl};
        // Host framing applies the word only after the strobe has risen
        take = cs.pend && (!host_mode || strobe_s);
        wa   = lnk.word[odc_pkg::ADDR_MSB:odc_pkg::ADDR_LSB];
        raw  = lnk.word[11:0];
        pay  = trim(raw);
        if (take)
            next_cs.pend = 1'b0;
        // A fresh word wins over the clear of the old one
        if (cs.tgl_s[2] != cs.tgl_s[1])
            next_cs.pend = 1'b1;
        if (take)
        begin
            // Control bits are never trimmed by the variant
            case (wa)
                odc_pkg::ADDR_MAIN:
                    next_cs.main = raw[4:0] & odc_pkg::MAIN_MASK;
                odc_pkg::ADDR_PAIR:
                    next_cs.pair = raw[7:0] & odc_pkg::CTRL_MASK;
                odc_pkg::ADDR_PRESET:
                    next_cs.preset = pay;
                odc_pkg::ADDR_RSVD:
                    next_cs.preset = cs.preset;
                default:
                begin
                    if (!wa[3])
                        next_cs.hold[wa[2:0]*12 +: 12] = pay;
                    else
                    begin
                        next_cs.hold[wa[1:0]*24 +: 12]      = pay;
                        next_cs.hold[wa[1:0]*24 + 12 +: 12] = trim(~pay);
                    end
                end
            endcase
        end
        if (!load_s)
        begin
            if (!preset_s)
                next_cs.latch = {odc_pkg::CHANNELS{cs.preset}};
            else
                next_cs.latch = next_cs.hold;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cs <= '0;
        else
            cs <= next_cs;
    end

    always_ff @(negedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
            serial_out <= 1'b0;
        else
            // Launched one edge early so a downstream part samples it 16 edges late
            serial_out <= lnk.delay[14] & do_en_link;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            channel_codes    <= '0;
            serial_out_en    <= 1'b0;
            device_powerdown <= 1'b0;
            reference_select <= 2'h0;
            code_format      <= 1'b0;
            pair_powerdown   <= 4'h0;
            pair_speed       <= 4'h0;
        end
        else
        begin
            channel_codes    <= cs.latch;
            serial_out_en    <= cs.main[odc_pkg::MAIN_DO_BIT];
            device_powerdown <= cs.main[odc_pkg::MAIN_PD_BIT];
            reference_select <= cs.main[odc_pkg::MAIN_REF_HI:odc_pkg::MAIN_REF_LO];
            code_format      <= cs.main[odc_pkg::MAIN_FMT_BIT];
            pair_powerdown   <= cs.pair[odc_pkg::PAIR_PD_LSB +: 4];
            pair_speed       <= cs.pair[odc_pkg::PAIR_SPD_LSB +: 4];
        end
    end

    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence load_active;
        !load_s && preset_s;
    endsequence

    preset_drive_a: assert property (!load_s && !preset_s |=> cs.latch == {8{$past(cs.preset)}})
        else $error("preset not driven");
    load_copy_a: assert property (load_active |=> cs.latch == $past(next_cs.hold))
        else $error("load copy wrong");
    hold_latch_a: assert property (load_s |=> $stable(cs.latch))
        else $error("latch moved without load");
    pd_out_a: assert property (##1 device_powerdown == $past(cs.main[4]))
        else $error("powerdown mismatch");
    ref_out_a: assert property (##1 reference_select == $past(cs.main[2:1]))
        else $error("reference mismatch");
    fmt_out_a: assert property (##1 code_format == $past(cs.main[0]))
        else $error("format mismatch");
    pair_pd_a: assert property (##1 pair_powerdown == $past(cs.pair[7:4]))
        else $error("pair powerdown mismatch");
    pair_spd_a: assert property (##1 pair_speed == $past(cs.pair[3:0]))
        else $error("pair speed mismatch");
    rsvd_write_a: assert property (take && lnk.word[15:12] == odc_pkg::ADDR_RSVD
        |=> $stable(cs.hold) && $stable(cs.main) && $stable(cs.pair)
        && $stable(cs.preset))
        else $error("reserved write changed state");

    sequence main_taken;
        take && lnk.word[15:12] == odc_pkg::ADDR_MAIN;
    endsequence

    main_write_a: assert property (main_taken |=> cs.main == $past(lnk.word[4:0]))
        else $error("main control not written");
    pair_write_a: assert property (take && lnk.word[15:12] == odc_pkg::ADDR_PAIR
        |=> cs.pair == $past(lnk.word[7:0]))
        else $error("pair control not written");
    host_wait_a: assert property (cs.pend && host_mode && !strobe_s |=> cs.pend)
        else $error("word applied before strobe rise");
    pend_set_a: assert property (cs.tgl_s[2] != cs.tgl_s[1] |=> cs.pend)
        else $error("completed word not pending");
    so_en_out_a: assert property (##1 serial_out_en == $past(cs.main[3]))
        else $error("pass-through enable mismatch");
endmodule
`default_nettype wire

// File: sim/odc_host_model.sv
// Host serial port model for the converter link
`timescale 1ns/10ps
`default_nettype none
module odc_host_model
(
    // Link towards the core
    output var  logic link_clk,
    output var  logic frame_strobe_b,
    output var  logic serial_in,
    // Pass-through back from the core
    input  wire logic serial_out
);
    logic sent [$];
    logic seen [$];

    initial
    begin
        link_clk       = 1'b1;
        frame_strobe_b = 1'b1;
        serial_in      = 1'b0;
    end

    // Clock stands still between frames in host mode, one pulse before a processor frame; idle data is inverted
    task automatic send(input logic [15:0] word, input int nbits, input logic host);
        #3.7;
        if (!host)
        begin
            link_clk = 1'b0;
            #3 link_clk = 1'b1;
        end
        #3 frame_strobe_b = 1'b0;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            serial_in = word[i];
            #3 link_clk = 1'b0;
            sent.push_back(word[i]);
            // Value seen by a downstream device at this edge
            seen.push_back(serial_out);
            #3 link_clk = 1'b1;
        end
        #3 frame_strobe_b = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the octal converter control core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic              core_clk, rst_b, link_clk, frame_strobe_b, serial_in, host_mode;
    logic              serial_out, serial_out_en, load_input_b, preset_b;
    logic              device_powerdown, code_format;
    logic [1:0]        reference_select;
    logic [3:0]        pair_powerdown, pair_speed;
    logic [95:0]       channel_codes, lat;
    logic [11:0]       hold [8];
    logic [11:0]       preset;
    logic [4:0]        main;
    logic [7:0]        pair;
    logic [31:0]       r;
    int                bad_count, cmp_count, seed, n, s;
    wire  logic [12:0] ctl_seen = {device_powerdown, reference_select, code_format,
                                   pair_powerdown, pair_speed, serial_out_en};

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Ten-bit variant so that dropping of low payload bits shows
    odc_core #(.RESOLUTION(odc_pkg::RES_10)) dut_u
    (
        .core_clk, .rst_b, .link_clk, .frame_strobe_b, .serial_in, .host_mode,
        .serial_out, .serial_out_en, .load_input_b, .preset_b, .channel_codes,
        .device_powerdown, .reference_select, .code_format, .pair_powerdown, .pair_speed
    );

    odc_host_model host_u
    (
        .link_clk, .frame_strobe_b, .serial_in, .serial_out
    );

    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [95:0] packed_hold();
        logic [95:0] v;
        for (int i = 0; i < 8; i++)
            v[i*12 +: 12] = hold[i];
        return v;
    endfunction

    // Expected effect of one complete word
    task automatic apply(input logic [15:0] wd);
        logic [11:0] d;
        d = wd[11:0] & odc_pkg::MASK_TEN;
        if (wd[15:12] < 4'h8)
            hold[wd[14:12]] = d;
        else if (wd[15:12] == 4'h8)
            main = wd[4:0];
        else if (wd[15:12] == 4'h9)
            pair = wd[7:0];
        else if (wd[15:12] == 4'ha)
            preset = d;
        else if (wd[15:12] >= 4'hc)
        begin
            hold[{wd[13:12], 1'b0}] = d;
            hold[{wd[13:12], 1'b1}] = ~wd[11:0] & odc_pkg::MASK_TEN;
        end
    endtask

    // Bounded wait for the outputs to reach the expectation
    task automatic settle(input int lim);
        logic [12:0] ctl;
        ctl = {main[4], main[2:0], pair, main[3]};
        n = 0;
        while (n < lim && !(channel_codes === lat && ctl_seen === ctl))
        begin
            @(posedge core_clk);
            n++;
        end
        check("codes", lat, channel_codes);
        check("controls", 96'(ctl), 96'(ctl_seen));
        // Still off after the bound: already counted, end the run
        if (channel_codes !== lat || ctl_seen !== ctl)
            conclude();
    endtask

    task automatic write(input logic [15:0] wd);
        // Low preset bits cleared: their trimming is a variant choice
        if (wd[15:12] == 4'ha)
            wd[3:0] = 4'h0;
        host_u.send(wd, 16, host_mode);
        apply(wd);
        if (!load_input_b)
            lat = preset_b ? packed_hold() : {8{preset}};
        repeat (12) @(posedge core_clk);
        settle(40);
    endtask

    task automatic pins(input logic ld, input logic pr);
        @(posedge core_clk);
        load_input_b <= ld;
        preset_b     <= pr;
        @(posedge core_clk);
        if (!ld)
            lat = pr ? packed_hold() : {8{preset}};
        repeat (12) @(posedge core_clk);
        settle(40);
    endtask

    initial
    begin
        seed         = 32'h157c167b;
        bad_count    = 0;
        cmp_count    = 0;
        rst_b        = 1'b0;
        host_mode    = 1'b1;
        load_input_b = 1'b0;
        preset_b     = 1'b1;
        preset       = '0;
        main         = '0;
        pair         = '0;
        lat          = '0;
        foreach (hold[i])
            hold[i] = '0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        settle(1);
        write(16'h0abc);
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        write(16'ha5a0);
        pins(1'b0, 1'b0);
        // Load rises first so the preset image stays latched
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        write(16'hc777);
        pins(1'b0, 1'b1);
        host_u.send(16'h0111, 10, 1'b1);
        repeat (12) @(posedge core_clk);
        settle(1);
        for (int k = 0; k < 32; k++)
            write({k[3:0], k[4] ? 12'h003 : 12'hfff});
        repeat (60)
        begin
            r = $random(seed);
            write(r[15:0]);
        end
        write(16'h8008);
        write(16'h1234);
        write(16'hd5c3);
        s = host_u.sent.size();
        for (int i = 0; i < 16; i++)
            check("pass", 96'(host_u.sent[s-32+i]), 96'(host_u.seen[s-16+i]));
        write(16'h8000);
        // Pass-through gate moves only on link edges, so send one more word
        write(16'h0123);
        check("pass_off", 96'h0, 96'(serial_out));
        @(posedge core_clk);
        host_mode <= 1'b0;
        @(posedge core_clk);
        repeat (20)
        begin
            r = $random(seed);
            write(r[15:0]);
        end
        conclude();
    end
endmodule
`default_nettype wire
